// *** rtl/cei_cfg.svh ***
// cei_cfg.svh: register offsets, field positions and reset values
// assumes a 16-bit register port with word offsets
`ifndef CEI_CFG_SVH
`define CEI_CFG_SVH
// ==========================================
// register offsets
`define CEI_CTRL 16'h7428
`define CEI_STAT 16'h7429
`define CEI_DATA0 16'h7440
`define CEI_FLG_A 16'h742F
`define CEI_FLG_B 16'h7430
`define CEI_FLG_C 16'h7431
`define CEI_MSK_A 16'h7444
`define CEI_MSK_B 16'h7445
`define CEI_MSK_C 16'h7446
`define CEI_VEC_A 16'h7447
`define CEI_VEC_B 16'h7448
`define CEI_VEC_C 16'h7449
// ==========================================
// field positions
`define CEI_CLR_BIT 15
`define CEI_EN_LSB 11
`define CEI_TSEL_BIT 10
`define CEI_STAT_LSB 8
`define CEI_T1OVF_BIT 10
`define CEI_CMP2_BIT 2
`define CEI_T3OVF_BIT 7
`define CEI_CAP4_BIT 3
// ==========================================
// reset values
`define CEI_RST16 16'h0000
`endif

// *** rtl/cei_pkg.sv ***
// cei_pkg: types of the capture and event interrupt block
// assumes cei_cfg.svh for the numbers
package cei_pkg;
    // ==========================================
    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cei_req_t;
    // ==========================================
    // whole state of the block
    typedef struct packed {
        logic [15:0] rdata;
        logic [15:0] flg_a;
        logic [15:0] flg_b;
        logic [15:0] flg_c;
        logic [15:0] msk_a;
        logic [15:0] msk_b;
        logic [15:0] msk_c;
        logic [3:0] en;
        logic tsel;
        logic [7:0] edge_sel;
        logic [3:0] pin_q;
        logic [3:0][1:0] cnt;
        logic [3:0][1:0][15:0] fifo;
    } cei_st_t;
endpackage : cei_pkg

// *** rtl/cei_top.sv ***
// cei_top: four capture units with two-deep stacks, three flag groups
// assumes capture pins and timer counts synchronous to ref_clk
//
// How it works
// R1: enabled edge stacks timer count, sets flag
// R2: control bit 15 write-only, reads zero
// R3: writing zero to bit 15 clears captures
// R4: write-one bits empty stack status pairs
// R5: group request needs set, unmasked, cpu-enabled
// R6: writing one clears a flag, zero keeps
// R7: vector read returns zero when none pending
// R8: group a bit 10 is timer1 overflow
// R9: group a bit 2 is full compare2
// R10: group b bit 7 is timer3 overflow
// R11: group c bit 3 is capture4 flag
// R12: software sets up/down mode for decoder; this block has no such mode bit, timer 3 count comes in on t3_cnt
// R13: vector read returns lowest pending, clears it
// R14: stacks hold two, status gives count
`timescale 1ns/1ps
`default_nettype none
`include "cei_cfg.svh"
module cei_top (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    // register port
    input wire cei_pkg::cei_req_t bus_req,
    output logic [15:0] rdata,
    // event sources
    input wire logic [3:0] cap_pin,
    input wire logic [15:0] t2_cnt,
    input wire logic [15:0] t3_cnt,
    input wire logic timer1_ovf,
    input wire logic cmp2_match,
    input wire logic timer3_ovf,
    // interrupt requests
    input wire logic [2:0] cpu_en,
    output logic [2:0] irq_grp,
    output logic irq
);
    import cei_pkg::*;

    // ==========================================
    // lowest pending bit, as index plus one
    function automatic logic [15:0] cei_vec(input logic [15:0] p);
        logic [15:0] v;
        v = `CEI_RST16;
        for (int i = 15; i >= 0; i--) begin
            if (p[i]) begin
                v = 16'(i + 1);
            end
        end
        return v;
    endfunction : cei_vec

    cei_st_t st_r;
    cei_st_t st_nxt;
    logic [3:0] hit;
    logic [15:0] cap_val;
    logic [15:0] pa;
    logic [15:0] pb;
    logic [15:0] pc;
    logic wr_ctrl;
    logic wr_stat;

    assign pa = st_r.flg_a & st_r.msk_a;
    assign pb = st_r.flg_b & st_r.msk_b;
    assign pc = st_r.flg_c & st_r.msk_c;
    assign cap_val = st_r.tsel ? t3_cnt : t2_cnt;
    assign wr_ctrl = ce && bus_req.wr && bus_req.addr == `CEI_CTRL;
    assign wr_stat = ce && bus_req.wr && bus_req.addr == `CEI_STAT;

    // ==========================================
    // edge detect per unit
    always_comb begin
        for (int u = 0; u < 4; u++) begin
            hit[u] = st_r.en[u] && (
                (st_r.edge_sel[2*u] && cap_pin[u] && !st_r.pin_q[u]) ||
                (st_r.edge_sel[2*u+1] && !cap_pin[u] && st_r.pin_q[u])); // R1
        end
    end

    // ==========================================
    // next state
    always_comb begin
        logic [15:0] rv;
        logic [15:0] ca;
        logic [15:0] cb;
        logic [15:0] cc;
        rv = `CEI_RST16;
        ca = `CEI_RST16;
        cb = `CEI_RST16;
        cc = `CEI_RST16;
        st_nxt = st_r;
        if (ce) begin
            st_nxt.pin_q = cap_pin;
            // register writes
            if (bus_req.wr) begin
                case (bus_req.addr)
                    `CEI_CTRL: begin
                        st_nxt.en = bus_req.wdata[`CEI_EN_LSB +: 4];
                        st_nxt.tsel = bus_req.wdata[`CEI_TSEL_BIT];
                        st_nxt.edge_sel = bus_req.wdata[7:0];
                        if (!bus_req.wdata[`CEI_CLR_BIT]) begin
                            st_nxt.cnt = '0; // R3
                            st_nxt.fifo = '0; // R3
                        end
                    end
                    `CEI_STAT: begin
                        for (int u = 0; u < 4; u++) begin
                            if (|bus_req.wdata[2*u +: 2]) begin
                                st_nxt.cnt[u] = 2'h0; // R4
                            end
                        end
                    end
                    `CEI_FLG_A: ca = bus_req.wdata; // R6
                    `CEI_FLG_B: cb = bus_req.wdata; // R6
                    `CEI_FLG_C: cc = bus_req.wdata; // R6
                    `CEI_MSK_A: st_nxt.msk_a = bus_req.wdata;
                    `CEI_MSK_B: st_nxt.msk_b = bus_req.wdata;
                    `CEI_MSK_C: st_nxt.msk_c = bus_req.wdata;
                    default: ;
                endcase
            end
            // register reads, with their side effects
            if (bus_req.rd) begin
                case (bus_req.addr)
                    `CEI_CTRL: rv = {1'b0, st_r.en, st_r.tsel, 2'h0, st_r.edge_sel}; // R2
                    `CEI_STAT: rv = {st_r.cnt, 8'h00}; // R14
                    `CEI_FLG_A: rv = st_r.flg_a;
                    `CEI_FLG_B: rv = st_r.flg_b;
                    `CEI_FLG_C: rv = st_r.flg_c;
                    `CEI_MSK_A: rv = st_r.msk_a;
                    `CEI_MSK_B: rv = st_r.msk_b;
                    `CEI_MSK_C: rv = st_r.msk_c;
                    `CEI_VEC_A: begin
                        rv = cei_vec(pa); // R7 R13
                        if (pa != 16'h0000) begin
                            ca[rv[3:0] - 4'h1] = 1'b1; // R13
                        end
                    end
                    `CEI_VEC_B: begin
                        rv = cei_vec(pb); // R7 R13
                        if (pb != 16'h0000) begin
                            cb[rv[3:0] - 4'h1] = 1'b1; // R13
                        end
                    end
                    `CEI_VEC_C: begin
                        rv = cei_vec(pc); // R7 R13
                        if (pc != 16'h0000) begin
                            cc[rv[3:0] - 4'h1] = 1'b1; // R13
                        end
                    end
                    default: begin
                        // stack reads pop the oldest entry
                        for (int u = 0; u < 4; u++) begin
                            if (bus_req.addr == `CEI_DATA0 + 16'(u)) begin
                                rv = st_r.fifo[u][0];
                                st_nxt.fifo[u][0] = st_r.fifo[u][1];
                                if (st_r.cnt[u] != 2'h0) begin
                                    st_nxt.cnt[u] = st_r.cnt[u] - 2'h1; // R14
                                end
                            end
                        end
                    end
                endcase
            end
            st_nxt.rdata = rv;
            // captures push after any pop; a full stack drops its oldest
            for (int u = 0; u < 4; u++) begin
                if (hit[u]) begin
                    case (st_nxt.cnt[u])
                        2'h0: begin
                            st_nxt.fifo[u][0] = cap_val; // R1
                            st_nxt.cnt[u] = 2'h1; // R14
                        end
                        2'h1: begin
                            st_nxt.fifo[u][1] = cap_val; // R1
                            st_nxt.cnt[u] = 2'h2; // R14
                        end
                        default: begin
                            st_nxt.fifo[u][0] = st_nxt.fifo[u][1];
                            st_nxt.fifo[u][1] = cap_val; // R1
                            st_nxt.cnt[u] = 2'h2;
                        end
                    endcase
                end
            end
            // flags: clears first so a same-cycle event wins
            st_nxt.flg_a = st_r.flg_a & ~ca;
            st_nxt.flg_b = st_r.flg_b & ~cb;
            st_nxt.flg_c = st_r.flg_c & ~cc;
            if (wr_ctrl && !bus_req.wdata[`CEI_CLR_BIT]) begin
                st_nxt.flg_c[3:0] = 4'h0; // R3
            end
            st_nxt.flg_a[`CEI_T1OVF_BIT] = st_nxt.flg_a[`CEI_T1OVF_BIT] | timer1_ovf; // R8
            st_nxt.flg_a[`CEI_CMP2_BIT] = st_nxt.flg_a[`CEI_CMP2_BIT] | cmp2_match; // R9
            st_nxt.flg_b[`CEI_T3OVF_BIT] = st_nxt.flg_b[`CEI_T3OVF_BIT] | timer3_ovf; // R10
            st_nxt.flg_c[3:0] = st_nxt.flg_c[3:0] | hit; // R1 R11
            // only documented flag bits exist
            st_nxt.flg_a = st_nxt.flg_a & 16'h0404;
            st_nxt.flg_b = st_nxt.flg_b & 16'h0080;
            st_nxt.flg_c = st_nxt.flg_c & 16'h000F;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // outputs
    assign rdata = st_r.rdata;
    assign irq_grp[0] = (pa != 16'h0000) && cpu_en[0]; // R5
    assign irq_grp[1] = (pb != 16'h0000) && cpu_en[1]; // R5
    assign irq_grp[2] = (pc != 16'h0000) && cpu_en[2]; // R5
    assign irq = |irq_grp;

    // ==========================================
    // checks
    cap4_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
        ce && hit[3] |=> st_r.flg_c[`CEI_CAP4_BIT])
        else $error("capture4 flag not set");
    cap_push_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
        ce && hit[0] && st_r.cnt[0] == 2'h0 && !bus_req.wr && !bus_req.rd
        |=> st_r.cnt[0] == 2'h1 && st_r.fifo[0][0] == $past(cap_val))
        else $error("capture not stacked");
    ctrl_msb_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R2
        ce && bus_req.rd && bus_req.addr == `CEI_CTRL |=> !rdata[15])
        else $error("control bit 15 read back");
    clr_all_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
        wr_ctrl && !bus_req.wdata[15] && hit == 4'h0
        |=> st_r.cnt == '0 && st_r.flg_c[3:0] == 4'h0)
        else $error("clear-all left captures");
    stat_clr_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R4
        wr_stat && bus_req.wdata[7] && !hit[3] |=> st_r.cnt[3] == 2'h0)
        else $error("stack status not cleared");
    irq_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R5
        ce && hit[3] && st_r.msk_c[`CEI_CAP4_BIT] && !bus_req.wr |=> irq_grp[2] || !cpu_en[2])
        else $error("group c request wrong");
    irq_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R5
        (st_r.msk_a & 16'h0404) == 16'h0000 || !cpu_en[0] |-> !irq_grp[0])
        else $error("group a request without cause");
    w1c_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R6
        ce && bus_req.wr && bus_req.addr == `CEI_FLG_B && bus_req.wdata[7] && !timer3_ovf
        |=> !st_r.flg_b[`CEI_T3OVF_BIT])
        else $error("write one did not clear");
    w0_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R6
        ce && bus_req.wr && bus_req.addr == `CEI_FLG_B && !bus_req.wdata[7]
        && st_r.flg_b[7] |=> st_r.flg_b[`CEI_T3OVF_BIT])
        else $error("write zero cleared flag");
    vec_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
        ce && bus_req.rd && bus_req.addr == `CEI_VEC_A && pa == 16'h0000 |=> rdata == 16'h0000)
        else $error("vector not zero");
    t1_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R8
        ce && timer1_ovf |=> st_r.flg_a[`CEI_T1OVF_BIT])
        else $error("timer1 flag not set");
    cmp2_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R9
        ce && cmp2_match |=> st_r.flg_a[`CEI_CMP2_BIT])
        else $error("compare2 flag not set");
    t3_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
        ce && timer3_ovf |=> st_r.flg_b[`CEI_T3OVF_BIT])
        else $error("timer3 flag not set");
    vec_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
        ce && bus_req.rd && bus_req.addr == `CEI_VEC_C && pc[3:0] == 4'h8 && !hit[3]
        |=> rdata == 16'h0004 && !st_r.flg_c[`CEI_CAP4_BIT])
        else $error("vector code or clear wrong");
    fifo_cnt_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        st_r.cnt[0] != 2'h3 && st_r.cnt[1] != 2'h3 && st_r.cnt[2] != 2'h3 && st_r.cnt[3] != 2'h3)
        else $error("stack count out of range");

    // ==========================================
    // checks on freeze, clears and captures
    // a low enable must hold every field, else a pulse seen while frozen leaks in
    ce_freeze_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
        !ce |=> st_r == $past(st_r))
        else $error("state moved while frozen");

    cap1_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
        ce && hit[0] |=> st_r.flg_c[0])
        else $error("capture1 flag not set");

    cnt_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        ce && !hit[1] && !bus_req.wr && !bus_req.rd
        |=> st_r.cnt[1] == $past(st_r.cnt[1]))
        else $error("stack count moved without cause");

    clr_fifo_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
        wr_ctrl && !bus_req.wdata[`CEI_CLR_BIT] && hit == 4'h0
        |=> st_r.fifo == '0)
        else $error("clear-all left stack data");

    // enabling with bit 15 high must not disturb the stacks
    clr_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
        wr_ctrl && bus_req.wdata[`CEI_CLR_BIT] && hit == 4'h0
        |=> st_r.cnt == $past(st_r.cnt))
        else $error("control write disturbed stacks");

    stat_clr_c_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R4
        wr_stat && bus_req.wdata[5:4] != 2'h0 && !hit[2] |=> st_r.cnt[2] == 2'h0)
        else $error("unit3 status not cleared");

    // ==========================================
    // checks on flags and vectors
    // flags are sticky: only a write of one, a vector read or, for the group c capture flags, a control write with bit 15 low may drop them
    t1_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R8
        ce && !bus_req.wr && !bus_req.rd && st_r.flg_a[`CEI_T1OVF_BIT]
        |=> st_r.flg_a[`CEI_T1OVF_BIT])
        else $error("timer1 flag dropped");

    t3_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
        ce && !bus_req.wr && !bus_req.rd && st_r.flg_b[`CEI_T3OVF_BIT]
        |=> st_r.flg_b[`CEI_T3OVF_BIT])
        else $error("timer3 flag dropped");

    cap4_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
        ce && !bus_req.wr && !bus_req.rd && st_r.flg_c[`CEI_CAP4_BIT]
        |=> st_r.flg_c[`CEI_CAP4_BIT])
        else $error("capture4 flag dropped");

    vec_zero_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
        ce && bus_req.rd && bus_req.addr == `CEI_VEC_B && pb == 16'h0000 |=> rdata == 16'h0000)
        else $error("group b vector not zero");

    vec_zero_c_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
        ce && bus_req.rd && bus_req.addr == `CEI_VEC_C && pc == 16'h0000 |=> rdata == 16'h0000)
        else $error("group c vector not zero");

    vec_clr_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
        ce && bus_req.rd && bus_req.addr == `CEI_VEC_A && pa[`CEI_CMP2_BIT] && !cmp2_match
        |=> rdata == 16'h0003 && !st_r.flg_a[`CEI_CMP2_BIT])
        else $error("group a vector code or clear wrong");

    // ==========================================
    // checks on stack order
    // a full stack keeps the newest pair, so the older entry moves down
    full_drop_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        ce && hit[3] && st_r.cnt[3] == 2'h2 && !bus_req.wr && !bus_req.rd
        |=> st_r.cnt[3] == 2'h2 && st_r.fifo[3][0] == $past(st_r.fifo[3][1]))
        else $error("full stack did not drop oldest");

    pop_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        ce && bus_req.rd && bus_req.addr == `CEI_DATA0 && st_r.cnt[0] == 2'h1 && !hit[0]
        |=> st_r.cnt[0] == 2'h0 && rdata == $past(st_r.fifo[0][0]))
        else $error("stack pop wrong");
endmodule : cei_top
`default_nettype wire

// *** verification/cei_far_model.sv ***
// cei_far_model: capture pin driver standing in for the outside sensors
// assumes one-cycle fire requests launched just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cei_far_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // requests from the bench
    input wire logic [3:0] fire,
    // capture pins
    output logic [3:0] cap_pin
);
    logic [3:0] hold_r;
    // ==========================================
    // pulse pins
    // two cycles high so a slow edge detector still sees the level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_pin <= 4'h0;
            hold_r <= 4'h0;
        end else begin
            hold_r <= fire;
            cap_pin <= fire | hold_r;
        end
    end
endmodule : cei_far_model
`default_nettype wire

// *** verification/cei_tb_top.sv ***
// cei_tb_top: self-checking bench for cei_top with queue model of stacks
// assumes cei_cfg.svh offsets and a register port with one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "cei_cfg.svh"
module cei_tb_top;
    import cei_pkg::*;
    logic ref_clk, arst_n, ce, timer1_ovf, cmp2_match, timer3_ovf, irq;
    cei_req_t bus_req;
    logic [15:0] rdata, t2_cnt, t3_cnt;
    logic [3:0] cap_pin, fire;
    logic [2:0] cpu_en, irq_grp;
    int n_mismatch, total_checks;
    int q[4][$];
    logic [15:0] regs[12] = '{`CEI_FLG_A, `CEI_FLG_B, `CEI_FLG_C, `CEI_MSK_A, `CEI_MSK_B,
        `CEI_MSK_C, `CEI_VEC_A, `CEI_VEC_B, `CEI_VEC_C, `CEI_CTRL, `CEI_STAT, 16'h7400};
    cei_top u_cei_top (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .bus_req(bus_req),
        .rdata(rdata), .cap_pin(cap_pin), .t2_cnt(t2_cnt), .t3_cnt(t3_cnt),
        .timer1_ovf(timer1_ovf), .cmp2_match(cmp2_match), .timer3_ovf(timer3_ovf),
        .cpu_en(cpu_en), .irq_grp(irq_grp), .irq(irq));
    cei_far_model u_cei_far_model (.ref_clk(ref_clk), .arst_n(arst_n), .fire(fire),
        .cap_pin(cap_pin));
    // ==========================================
    // helpers
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr
    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] exp,
        input logic [15:0] m = 16'hFFFF);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask : rd
    // one pin pulse on unit u; model keeps two entries, oldest dropped
    // with up_down the decoder-driven timer 3 steps one count either way
    task automatic cap(input int u, input bit up_down = 1'b0);
        logic [15:0] v;
        v = 16'($urandom);
        if (up_down) begin
            v = ($urandom % 2) ? t3_cnt + 16'h0001 : t3_cnt - 16'h0001;
        end
        @(posedge ref_clk);
        if (up_down) begin
            t3_cnt <= v;
        end else begin
            t2_cnt <= v;
        end
        fire <= 4'(1 << u);
        @(posedge ref_clk);
        fire <= 4'h0;
        repeat (4) @(posedge ref_clk);
        q[u].push_back(int'(v));
        if (q[u].size() > 2) void'(q[u].pop_front());
    endtask : cap
    task automatic pop_all;
        for (int u = 0; u < 4; u++) begin
            while (q[u].size() > 0) rd(16'(`CEI_DATA0 + u), 16'(q[u].pop_front()));
        end
    endtask : pop_all
    task automatic irq_is(input logic [2:0] g);
        @(posedge ref_clk);
        #1 chk({12'h000, irq, irq_grp}, {12'h000, |g, g});
    endtask : irq_is
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish in time", $time);
        give_verdict();
    end
    // ==========================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        bus_req = '0;
        {t2_cnt, t3_cnt, fire, timer1_ovf, cmp2_match, timer3_ovf} = '0;
        cpu_en = 3'h7;
        void'($urandom(53292));
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 12; i++) rd(regs[i], 16'h0000);
        @(posedge ref_clk);
        {timer1_ovf, cmp2_match, timer3_ovf} <= 3'h7;
        @(posedge ref_clk);
        {timer1_ovf, cmp2_match, timer3_ovf} <= 3'h0;
        rd(`CEI_FLG_A, 16'h0404);
        rd(`CEI_FLG_B, 16'h0080);
        irq_is(3'b000);
        wr(`CEI_FLG_A, 16'hFBFB);
        rd(`CEI_FLG_A, 16'h0404);
        wr(`CEI_MSK_A, 16'h0404);
        irq_is(3'b001);
        @(posedge ref_clk);
        cpu_en <= 3'h6;
        irq_is(3'b000);
        @(posedge ref_clk);
        cpu_en <= 3'h7;
        rd(`CEI_VEC_A, 16'h0003);
        rd(`CEI_VEC_A, 16'h000B);
        rd(`CEI_VEC_A, 16'h0000);
        irq_is(3'b000);
        wr(`CEI_FLG_B, 16'h0080);
        rd(`CEI_FLG_B, 16'h0000);
        wr(`CEI_CTRL, 16'hF855);
        rd(`CEI_CTRL, 16'h7855);
        for (int u = 0; u < 4; u++) cap(u);
        rd(`CEI_FLG_C, 16'h000F);
        rd(`CEI_STAT, 16'h5500);
        cap(3);
        cap(3);
        rd(`CEI_STAT, 16'h9500);
        pop_all();
        rd(`CEI_STAT, 16'h0000);
        for (int u = 1; u < 4; u++) cap(u);
        wr(`CEI_STAT, 16'h0090);
        q[3].delete();
        q[2].delete();
        rd(`CEI_STAT, 16'h0400);
        wr(`CEI_MSK_C, 16'h0008);
        irq_is(3'b100);
        wr(`CEI_CTRL, 16'h7855);
        q[1].delete();
        rd(`CEI_STAT, 16'h0000);
        rd(`CEI_FLG_C, 16'h0000);
        irq_is(3'b000);
        cap(3);
        rd(`CEI_FLG_C, 16'h0008);
        pop_all();
        rd(`CEI_VEC_C, 16'h0004);
        irq_is(3'b000);
        // a pulse while the enable is low must be lost
        @(posedge ref_clk);
        {ce, timer3_ovf} <= 2'b01;
        @(posedge ref_clk);
        {ce, timer3_ovf} <= 2'b10;
        rd(`CEI_FLG_B, 16'h0000);
        wr(`CEI_MSK_B, 16'h0080);
        @(posedge ref_clk);
        timer3_ovf <= 1'b1;
        @(posedge ref_clk);
        timer3_ovf <= 1'b0;
        irq_is(3'b010);
        wr(`CEI_FLG_B, 16'hFF7F);
        rd(`CEI_VEC_B, 16'h0008);
        // unit 1 alone, falling edge, timer 3 selected
        wr(`CEI_CTRL, 16'h8C02);
        cap(0, 1'b1);
        rd(`CEI_FLG_C, 16'h0001);
        pop_all();
        give_verdict();
    end
endmodule : cei_tb_top
`default_nettype wire
